// ### test_port_map.vh
// Functional notes
// - Forced reset drives CPU reset, clears prefetch count and emulation; control word keeps its value.
// - Forced reset loads program counter from vector.
// - Release starts execution at reset vector.
// - Takeover enable bit gives port CPU control.
// - Captured bit 9 reports control gained.
// - Full emulation needs suspend and emptied prefetch.
// - Captured bit 7 zero in instruction fetch.
`ifndef TEST_PORT_MAP_VH
`define TEST_PORT_MAP_VH
// ****************************************
// Instruction codes and widths.
// ****************************************
`define IR_WIDTH 8
`define DR_WIDTH 16
`define INSTR_CTRL_WRITE 8'h13
`define INSTR_CTRL_READ 8'h14
`define INSTR_CTRL_RELEASE 8'h15
`define INSTR_ADDR_CAPTURE 8'h05
`define INSTR_BYPASS 8'hff
// The identity code is arbitrary.
`define IR_CAPTURE_ID 8'h5a
// ****************************************
// Control word fields and reset values.
// ****************************************
`define CTRL_HALT_BIT 3
`define CTRL_FETCH_BIT 7
`define CTRL_SUSPEND_BIT 8
`define CTRL_GAINED_BIT 9
`define CTRL_TAKEOVER_BIT 10
`define CTRL_POR_BIT 11
`define CTRL_RESET_VALUE 16'h0000
`define RESET_VECTOR_ADDR 16'hfffe
`define PREFETCH_DEPTH 4
`endif

// ### test_port_ctrl.v
`timescale 1ns/1ps
`include "test_port_map.vh"
module test_port_ctrl #(
   parameter PREFETCH = `PREFETCH_DEPTH
)
(
   input wire clk,
   input wire rstn,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire test_step_clock,
   input wire cpu_fetch_state,
   input wire [15:0] reset_vector_data,
   output reg tdo_q,
   output reg tdo_oe_n_q,
   output reg cpu_por_q,
   output reg cpu_suspend_q,
   output reg cpu_halt_q,
   output reg under_control_q,
   output reg cpu_step_q,
   output reg full_emulation_q,
   output reg released_q,
   output reg [15:0] vector_addr_q,
   output reg [15:0] pc_q
);
   // ****************************************
   // TAP states.
   // ****************************************
   localparam S_RESET = 4'h0;
   localparam S_IDLE = 4'h1;
   localparam S_SEL_DR = 4'h2;
   localparam S_CAP_DR = 4'h3;
   localparam S_SH_DR = 4'h4;
   localparam S_EX1_DR = 4'h5;
   localparam S_PA_DR = 4'h6;
   localparam S_EX2_DR = 4'h7;
   localparam S_UP_DR = 4'h8;
   localparam S_SEL_IR = 4'h9;
   localparam S_CAP_IR = 4'ha;
   localparam S_SH_IR = 4'hb;
   localparam S_EX1_IR = 4'hc;
   localparam S_PA_IR = 4'hd;
   localparam S_EX2_IR = 4'he;
   localparam S_UP_IR = 4'hf;

   reg [1:0] tck_s_q;
   reg [1:0] tms_s_q;
   reg [1:0] tdi_s_q;
   reg [1:0] step_s_q;
   reg tck_prev_q;
   reg step_prev_q;
   reg [3:0] tap_q;
   reg [3:0] tap_d;
   reg [`IR_WIDTH-1:0] ir_q;
   reg [`IR_WIDTH-1:0] ir_sh_q;
   reg [`DR_WIDTH-1:0] dr_sh_q;
   reg [`DR_WIDTH-1:0] ctrl_q;
   reg [3:0] prefetch_q;
   reg released_prev_q;
   wire tck_rise;
   wire tck_fall;
   wire step_rise;
   wire por_req;
   wire [`DR_WIDTH-1:0] ctrl_view;

   // Returns true when the instruction selects the 16-bit register.
   function is_word_instr;
      input [`IR_WIDTH-1:0] ins;
      begin
         is_word_instr = (ins == `INSTR_CTRL_WRITE) || (ins == `INSTR_CTRL_READ)
            || (ins == `INSTR_ADDR_CAPTURE);
      end
   endfunction

   // ****************************************
   // Pin synchronisers and edge detection.
   // ****************************************
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tck_s_q <= 2'h3;
         tms_s_q <= 2'h3;
         tdi_s_q <= 2'h0;
         step_s_q <= 2'h3;
         tck_prev_q <= 1'b1;
         step_prev_q <= 1'b1;
      end
      else
      begin
         tck_s_q <= {tck_s_q[0], tck};
         tms_s_q <= {tms_s_q[0], tms};
         tdi_s_q <= {tdi_s_q[0], tdi};
         step_s_q <= {step_s_q[0], test_step_clock};
         tck_prev_q <= tck_s_q[1];
         step_prev_q <= step_s_q[1];
      end
   end

   assign tck_rise = tck_s_q[1] & ~tck_prev_q;
   assign tck_fall = ~tck_s_q[1] & tck_prev_q;
   assign step_rise = step_s_q[1] & ~step_prev_q;
   assign por_req = ctrl_q[`CTRL_POR_BIT];
   // Captured view reports control gained and fetch state.
   assign ctrl_view = {ctrl_q[15:10], under_control_q, ctrl_q[8], ~cpu_fetch_state,
      ctrl_q[6:0]};

   // ****************************************
   // TAP state machine.
   // ****************************************
   always @*
   begin
      tap_d = tap_q;
      case (tap_q)
         S_RESET: tap_d = tms_s_q[1] ? S_RESET : S_IDLE;
         S_IDLE: tap_d = tms_s_q[1] ? S_SEL_DR : S_IDLE;
         S_SEL_DR: tap_d = tms_s_q[1] ? S_SEL_IR : S_CAP_DR;
         S_CAP_DR: tap_d = tms_s_q[1] ? S_EX1_DR : S_SH_DR;
         S_SH_DR: tap_d = tms_s_q[1] ? S_EX1_DR : S_SH_DR;
         S_EX1_DR: tap_d = tms_s_q[1] ? S_UP_DR : S_PA_DR;
         S_PA_DR: tap_d = tms_s_q[1] ? S_EX2_DR : S_PA_DR;
         S_EX2_DR: tap_d = tms_s_q[1] ? S_UP_DR : S_SH_DR;
         S_UP_DR: tap_d = tms_s_q[1] ? S_SEL_DR : S_IDLE;
         S_SEL_IR: tap_d = tms_s_q[1] ? S_RESET : S_CAP_IR;
         S_CAP_IR: tap_d = tms_s_q[1] ? S_EX1_IR : S_SH_IR;
         S_SH_IR: tap_d = tms_s_q[1] ? S_EX1_IR : S_SH_IR;
         S_EX1_IR: tap_d = tms_s_q[1] ? S_UP_IR : S_PA_IR;
         S_PA_IR: tap_d = tms_s_q[1] ? S_EX2_IR : S_PA_IR;
         S_EX2_IR: tap_d = tms_s_q[1] ? S_UP_IR : S_SH_IR;
         S_UP_IR: tap_d = tms_s_q[1] ? S_SEL_DR : S_IDLE;
         default: tap_d = S_RESET;
      endcase
   end

   // ****************************************
   // Shift paths, instruction and control word.
   // ****************************************
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tap_q <= S_RESET;
         ir_q <= `INSTR_BYPASS;
         ir_sh_q <= {`IR_WIDTH{1'b0}};
         dr_sh_q <= {`DR_WIDTH{1'b0}};
         ctrl_q <= `CTRL_RESET_VALUE;
         released_q <= 1'b0;
      end
      else if (tck_rise)
      begin
         tap_q <= tap_d;
         case (tap_q)
            S_RESET:
            begin
               ir_q <= `INSTR_BYPASS;
            end
            S_CAP_IR: ir_sh_q <= `IR_CAPTURE_ID;
            S_SH_IR: ir_sh_q <= {tdi_s_q[1], ir_sh_q[`IR_WIDTH-1:1]};
            S_UP_IR:
            begin
               ir_q <= ir_sh_q;
               if (ir_sh_q == `INSTR_CTRL_RELEASE)
               begin
                  ctrl_q <= `CTRL_RESET_VALUE;
                  released_q <= 1'b1;
               end
            end
            S_CAP_DR:
            begin
               if (ir_q == `INSTR_ADDR_CAPTURE)
                  dr_sh_q <= pc_q;
               else if (is_word_instr(ir_q))
                  dr_sh_q <= ctrl_view;
               else
                  dr_sh_q <= {`DR_WIDTH{1'b0}};
            end
            S_SH_DR:
            begin
               if (is_word_instr(ir_q))
                  dr_sh_q <= {tdi_s_q[1], dr_sh_q[`DR_WIDTH-1:1]};
               else
                  dr_sh_q <= {{(`DR_WIDTH-1){1'b0}}, tdi_s_q[1]};
            end
            S_UP_DR:
            begin
               if (ir_q == `INSTR_CTRL_WRITE)
               begin
                  ctrl_q <= dr_sh_q;
                  released_q <= 1'b0;
               end
            end
            default:
            begin
               ir_q <= ir_q;
            end
         endcase
      end
   end

   // Output shifts out on the falling edge of the test clock.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tdo_q <= 1'b0;
         tdo_oe_n_q <= 1'b1;
      end
      else if (tck_fall)
      begin
         tdo_q <= (tap_q == S_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
         tdo_oe_n_q <= ~((tap_q == S_SH_IR) || (tap_q == S_SH_DR));
      end
   end

   // ****************************************
   // CPU control, stepping and program counter.
   // ****************************************
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cpu_por_q <= 1'b0;
         cpu_suspend_q <= 1'b0;
         cpu_halt_q <= 1'b0;
         under_control_q <= 1'b0;
         cpu_step_q <= 1'b0;
         full_emulation_q <= 1'b0;
         prefetch_q <= 4'h0;
         released_prev_q <= 1'b0;
         vector_addr_q <= `RESET_VECTOR_ADDR;
         pc_q <= 16'h0000;
      end
      else
      begin
         released_prev_q <= released_q;
         cpu_por_q <= por_req;
         cpu_suspend_q <= ctrl_q[`CTRL_SUSPEND_BIT];
         cpu_halt_q <= ctrl_q[`CTRL_HALT_BIT];
         under_control_q <= ctrl_q[`CTRL_TAKEOVER_BIT] & ~released_q;
         // One CPU cycle per rising step edge in Run-Test/Idle.
         cpu_step_q <= step_rise && (tap_q == S_IDLE) && under_control_q;
         vector_addr_q <= `RESET_VECTOR_ADDR;
         if (por_req)
         begin
            pc_q <= reset_vector_data;
            prefetch_q <= 4'h0;
            full_emulation_q <= 1'b0;
         end
         else if (released_q && !released_prev_q)
         begin
            pc_q <= reset_vector_data;
         end
         else
         begin
            if (!cpu_suspend_q)
               prefetch_q <= 4'h0;
            else if (cpu_step_q && prefetch_q < PREFETCH[3:0])
               prefetch_q <= prefetch_q + 4'h1;
            full_emulation_q <= cpu_suspend_q && (prefetch_q >= PREFETCH[3:0]);
            if (cpu_step_q && !cpu_suspend_q)
               pc_q <= pc_q + 16'h0002;
         end
      end
   end
endmodule // test_port_ctrl

// ### test_port_ctrl_sva.sv
`timescale 1ns/1ps
// ****
// Checker.
// ****
module test_port_ctrl_sva #(
   parameter PREFETCH = 4
)
(
   input wire clk,
   input wire rstn,
   input wire [15:0] reset_vector_data,
   input wire cpu_por_q,
   input wire cpu_suspend_q,
   input wire under_control_q,
   input wire cpu_step_q,
   input wire full_emulation_q,
   input wire released_q,
   input wire [15:0] vector_addr_q,
   input wire [15:0] pc_q
);
   reg [3:0] steps_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Counts step pulses since suspend was set.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         steps_q <= 4'h0;
      else if (!cpu_suspend_q)
         steps_q <= 4'h0;
      else if (cpu_step_q && steps_q != 4'hf)
         steps_q <= steps_q + 4'h1;
   end
   a_step_single: assert property (cpu_step_q |=> !cpu_step_q)
      else $error("step pulse too long");
   a_step_control: assert property (cpu_step_q |-> $past(under_control_q))
      else $error("step without control");
   a_emu_suspend: assert property ($rose(full_emulation_q) |-> cpu_suspend_q)
      else $error("emulation without suspend");
   a_emu_steps: assert property ($rose(full_emulation_q) |-> steps_q + cpu_step_q >= PREFETCH)
      else $error("emulation too early");
   a_emu_off: assert property (!cpu_suspend_q ##1 !cpu_suspend_q |-> !full_emulation_q)
      else $error("emulation kept");
   a_vector_fixed: assert property (vector_addr_q == 16'hfffe)
      else $error("vector address wrong");
   a_pc_after_por: assert property ($fell(cpu_por_q) |-> pc_q == reset_vector_data)
      else $error("pc not loaded");
   a_release_free: assert property (released_q && $past(released_q) |-> !under_control_q)
      else $error("control kept");
endmodule // test_port_ctrl_sva

// ### test_port_prog.sv
`timescale 1ns/1ps
`include "test_port_map.vh"
// ****
// Programmer model.
// ****
module test_port_prog (
   input wire clk,
   input wire tdo_pin,
   output reg tck = 1'b1,
   output reg tms = 1'b1,
   output reg tdi = 1'b0,
   output reg test_step_clock = 1'b1
);
   reg last_tdo;
   reg gained_q;
   reg [7:0] id_q;
   reg [15:0] word;
   task tick(input m, input d);
   begin
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (5) @(posedge clk);
      last_tdo = tdo_pin;
      tck <= 1'b1;
      repeat (3) @(posedge clk);
   end
   endtask
   task shift(input ir, input [15:0] v, input integer n);
      integer i;
   begin
      word = 16'h0000;
      tick(1'b1, ~v[0]);
      if (ir)
         tick(1'b1, v[0]);
      tick(1'b0, ~v[0]);
      tick(1'b0, v[0]);
      for (i = 0; i < n; i = i + 1)
      begin
         tick(i == n - 1, v[i]);
         word = {last_tdo, word[15:1]};
      end
      tick(1'b1, ~v[n - 1]);
      tick(1'b0, v[n - 1]);
   end
   endtask
   task step;
   begin
      test_step_clock <= 1'b0;
      repeat (4) @(posedge clk);
      test_step_clock <= 1'b1;
      repeat (4) @(posedge clk);
   end
   endtask
   task wr(input [15:0] v);
   begin
      shift(1'b1, `INSTR_CTRL_WRITE, 8);
      id_q = word[15:8];
      shift(1'b0, v, 16);
   end
   endtask
   task takeover_sequence;
   begin
      repeat (5) tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
      wr(16'h1501);
      shift(1'b1, `INSTR_CTRL_READ, 8);
      shift(1'b0, 16'h0000, 16);
      gained_q = word[9];
      step;
      wr(16'h0c01);
      wr(16'h0401);
      repeat (5) step;
      wr(16'h0501);
      step;
   end
   endtask
   task cpu_release_sequence;
   begin
      wr(16'h2401);
   end
   endtask
   task device_release_sequence;
   begin
      wr(16'h2c01);
      wr(16'h2401);
      shift(1'b1, `INSTR_CTRL_RELEASE, 8);
   end
   endtask
endmodule // test_port_prog

// ### test_port_ctrl_bench.sv
`timescale 1ns/1ps
`include "test_port_map.vh"
// ****
// Bench.
// ****
module test_port_ctrl_bench;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg cpu_fetch_state = 1'b0;
   reg [15:0] reset_vector_data = 16'h4400;
   wire tck, tms, tdi, test_step_clock, tdo_q, tdo_oe_n_q, cpu_por_q, cpu_suspend_q, cpu_halt_q;
   wire under_control_q, cpu_step_q, full_emulation_q, released_q;
   wire [15:0] pc_q;
   wire [15:0] word = test_port_prog_inst.word;
   integer fail_count = 0;
   integer total_checks = 0;
   integer steps = 0;
   integer cycles = 0;
   initial
   begin
      forever #50 clk = ~clk;
   end
   test_port_ctrl #(.PREFETCH(1)) test_port_ctrl_inst (.clk, .rstn, .tck, .tms, .tdi,
      .test_step_clock, .cpu_fetch_state, .reset_vector_data, .tdo_q, .tdo_oe_n_q, .cpu_por_q,
      .cpu_suspend_q, .cpu_halt_q, .under_control_q, .cpu_step_q, .full_emulation_q,
      .released_q, .vector_addr_q(), .pc_q);
   test_port_prog test_port_prog_inst (.clk, .tdo_pin(tdo_oe_n_q | tdo_q), .tck, .tms, .tdi,
      .test_step_clock);
   always @(negedge clk)
   begin
      cycles = cycles + 1;
      if (cpu_step_q === 1'b1)
         steps = steps + 1;
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         finish_test;
      end
   end
   task chk(input string name, input [15:0] exp, input [15:0] got);
   begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
   end
   endtask
   task rd(input [7:0] ir);
   begin
      test_port_prog_inst.shift(1'b1, ir, 8);
      test_port_prog_inst.shift(1'b0, 16'h0000, 16);
   end
   endtask
   task t_takeover;
   begin
      test_port_prog_inst.takeover_sequence;
      chk("id", `IR_CAPTURE_ID, test_port_prog_inst.id_q);
      chk("gained", 16'h1, test_port_prog_inst.gained_q);
      chk("steps", 16'h7, steps);
      repeat (2) @(posedge clk);
      chk("emulation", 16'h3, {full_emulation_q, cpu_suspend_q});
      rd(`INSTR_ADDR_CAPTURE);
      chk("pc", reset_vector_data + 16'ha, word);
      $display("done takeover");
   end
   endtask
   task t_fetch;
   begin
      cpu_fetch_state <= 1'b1;
      rd(`INSTR_CTRL_READ);
      chk("fetch", 16'h0, word[7]);
      cpu_fetch_state <= 1'b0;
      rd(`INSTR_CTRL_READ);
      chk("fetch", 16'h1, word[7]);
      chk("gained", 16'h1, word[9]);
      $display("done fetch");
   end
   endtask
   task t_por;
   begin
      test_port_prog_inst.wr(16'h2c01);
      repeat (2) @(posedge clk);
      chk("por", 16'h1, cpu_por_q);
      test_port_prog_inst.wr(16'h2401);
      repeat (2) @(posedge clk);
      chk("cpu", 16'h0, {cpu_por_q, cpu_suspend_q, cpu_halt_q, full_emulation_q});
      rd(`INSTR_ADDR_CAPTURE);
      chk("pc", reset_vector_data, word);
      test_port_prog_inst.step;
      rd(`INSTR_ADDR_CAPTURE);
      chk("pc", reset_vector_data + 16'h2, word);
      test_port_prog_inst.wr(16'h2409);
      repeat (2) @(posedge clk);
      chk("halt", 16'h1, cpu_halt_q);
      test_port_prog_inst.cpu_release_sequence;
      repeat (2) @(posedge clk);
      chk("halt", 16'h0, cpu_halt_q);
      $display("done reset");
   end
   endtask
   task t_release;
   begin
      test_port_prog_inst.device_release_sequence;
      repeat (4) @(posedge clk);
      chk("release", 16'h2, {released_q, under_control_q});
      chk("pc", reset_vector_data, pc_q);
      test_port_prog_inst.wr(16'h0401);
      repeat (2) @(posedge clk);
      chk("control", 16'h1, {released_q, under_control_q});
      test_port_prog_inst.step;
      repeat (2) @(posedge clk);
      chk("pc", reset_vector_data + 16'h2, pc_q);
      test_port_prog_inst.shift(1'b1, `INSTR_CTRL_RELEASE, 8);
      repeat (4) @(posedge clk);
      chk("pc", reset_vector_data, pc_q);
      $display("done release");
   end
   endtask
   task finish_test;
   begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_takeover;
      t_fetch;
      t_por;
      t_release;
      finish_test;
   end
endmodule // test_port_ctrl_bench
bind test_port_ctrl test_port_ctrl_sva #(.PREFETCH(PREFETCH)) sva_inst (.clk, .rstn,
   .reset_vector_data, .cpu_por_q, .cpu_suspend_q, .under_control_q, .cpu_step_q,
   .full_emulation_q, .released_q, .vector_addr_q, .pc_q);
